// ---- logic/oss_serial_ctrl.sv ----
// Serial command and fault-status logic of an eight-channel power switch.
// Assumes an external master supplies serial clock and chip select; all pins are asynchronous.
//
// Contract
// - Each transfer moves sixteen command bits in and sixteen status bits out.
// - Command and status words shift most significant bit first.
// - Command applies to drivers on chip select rising; drivers hold until then.
// - Command bits 0 to 7 switch outputs one to eight on when one.
// - Command bits 8 to 15 enable open-load sense current of outputs one to eight.
// - Status bits 0 to 7 flag short, open load or thermal limit per output.
// - Status bits 8 to 15 always read zero.
// - Returned status reflects the previously applied command, not the incoming one.
// - While selected, shifted data passes through toward the next chained device.
// - Off-state open load reported only with that channel's sense current enabled.
// - Open load while commanded on is never reported.
// - Over-current or short to supply sets that output's status bit.
// - Thermal limit turns off only that output, flags it, resumes when cleared.
// - Supply over-voltage forces all outputs off; they resume previous state after.
// - Sleep resets registers: all outputs off, sense currents disabled.
// - Sleep entered when enable is low or logic supply removed.
// - Input sampled on serial clock falling edges; output changes on rising edges.
// - With chip select high, clock and input ignored and output tri-stated.
// - Direct drive inputs five and six are ORed with their command bits.
// - Transfer acted on only if clock count is 16 plus a multiple of 8.
`timescale 1ns/1ps
`default_nettype none
module oss_serial_ctrl
  import oss_pkg::*;
#(
  parameter int CHANNELS = OSS_CHAN_NUM
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial link pins
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_command_in,
  output logic serial_status_out,
  output logic serial_status_oe,
  // Power and enable
  input wire logic enable,
  input wire logic logic_supply_ok,
  // Direct drive pins
  input wire logic direct_drive_fifth,
  input wire logic direct_drive_sixth,
  // Fault indications from the analog side
  input wire logic [CHANNELS-1:0] short_fault,
  input wire logic [CHANNELS-1:0] open_load_fault,
  input wire logic [CHANNELS-1:0] thermal_limit,
  input wire logic over_voltage,
  // Driver controls
  output logic [CHANNELS-1:0] driver_on,
  output logic [CHANNELS-1:0] sense_current_en,
  output logic [15:0] output_command_word
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  localparam int SYN_W = 7 + 3 * CHANNELS;
  logic [SYN_W-1:0] syn_raw;
  logic [SYN_W-1:0] syn_out;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic en_s;
  logic vdd_s;
  logic dd5_s;
  logic dd6_s;
  oss_fault_t flt_s;
  logic ov_s;

  assign syn_raw = {chip_select_n, serial_clk, serial_command_in, enable, logic_supply_ok,
                    direct_drive_fifth, direct_drive_sixth, short_fault, open_load_fault,
                    thermal_limit};

  oss_sync #(
    .WIDTH(SYN_W),
    .RESET_VAL({1'b1, {(SYN_W-1){1'b0}}})
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(syn_raw),
    .sync_out(syn_out)
  );

  oss_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_sync_ov (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(over_voltage),
    .sync_out(ov_s)
  );

  assign cs_n_s = syn_out[SYN_W-1];
  assign sclk_s = syn_out[SYN_W-2];
  assign din_s = syn_out[SYN_W-3];
  assign en_s = syn_out[SYN_W-4];
  assign vdd_s = syn_out[SYN_W-5];
  assign dd5_s = syn_out[SYN_W-6];
  assign dd6_s = syn_out[SYN_W-7];
  // Short, open load and thermal groups, then over-voltage in the lowest bit
  assign flt_s = {syn_out[3*CHANNELS-1:0], ov_s};

  // ----------------------------------------------------------------
  // Edge detection and sleep
  // ----------------------------------------------------------------
  logic cs_n_d_ff;
  logic sclk_d_ff;
  logic nxt_cs_n_d;
  logic nxt_sclk_d;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic sleep;

  always_comb begin
    nxt_cs_n_d = cs_n_s;
    nxt_sclk_d = sclk_s;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
    end else begin
      cs_n_d_ff <= nxt_cs_n_d;
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  assign cs_fall = cs_n_d_ff & ~cs_n_s;
  assign cs_rise = ~cs_n_d_ff & cs_n_s;
  assign sclk_fall = sclk_d_ff & ~sclk_s & ~cs_n_s;
  assign sclk_rise = ~sclk_d_ff & sclk_s & ~cs_n_s;
  assign sleep = ~en_s | ~vdd_s;

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  oss_state_t state_ff;
  oss_state_t nxt_state;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [OSS_CNT_W-1:0] cnt_ff;
  logic [OSS_CNT_W-1:0] nxt_cnt;
  logic dout_ff;
  logic nxt_dout;
  oss_cmd_t cmd_ff;
  oss_cmd_t nxt_cmd;
  logic [7:0] status_now;
  logic count_ok;

  // Open load counts only while commanded off and sense enabled
  assign status_now = flt_s.short_flt | flt_s.thermal_limit
                    | (flt_s.open_flt & ~cmd_ff.out_on & cmd_ff.old_en);

  assign count_ok = (cnt_ff >= OSS_CNT_W'(OSS_MIN_BITS)) &&
                    (cnt_ff[2:0] == 3'h0);

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    nxt_dout = dout_ff;
    nxt_cmd = cmd_ff;
    case (state_ff)
      OSS_IDLE: begin
        if (cs_fall) begin
          nxt_state = OSS_SHIFT;
          nxt_shift = {OSS_STAT_HIGH, status_now};
          nxt_dout = 1'b0;
          nxt_cnt = '0;
        end
      end
      OSS_SHIFT: begin
        if (cs_rise) begin
          nxt_state = OSS_IDLE;
          if (count_ok) begin
            nxt_cmd = oss_cmd_t'(shift_ff);
          end
        end else begin
          if (sclk_rise) begin
            nxt_dout = shift_ff[15];
          end
          if (sclk_fall) begin
            nxt_shift = {shift_ff[14:0], din_s};
            if (cnt_ff != {OSS_CNT_W{1'b1}}) begin
              nxt_cnt = cnt_ff + OSS_CNT_W'(1);
            end
          end
        end
      end
      default: nxt_state = OSS_IDLE;
    endcase
    if (sleep) begin
      nxt_state = OSS_IDLE;
      nxt_cmd = oss_cmd_t'(OSS_CMD_RESET);
      nxt_cnt = '0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= OSS_IDLE;
      shift_ff <= 16'h0000;
      cnt_ff <= '0;
      dout_ff <= 1'b0;
      cmd_ff <= oss_cmd_t'(OSS_CMD_RESET);
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
      dout_ff <= nxt_dout;
      cmd_ff <= nxt_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [7:0] drive_req;

  always_comb begin
    drive_req = cmd_ff.out_on;
    drive_req[4] = cmd_ff.out_on[4] | dd5_s;
    drive_req[5] = cmd_ff.out_on[5] | dd6_s;
  end

  // Over-voltage masks all; thermal masks one; command is kept for resume
  assign driver_on = (flt_s.over_voltage | sleep) ? '0
                   : (drive_req & ~flt_s.thermal_limit);
  assign sense_current_en = sleep ? '0 : cmd_ff.old_en;
  assign output_command_word = cmd_ff;
  assign serial_status_out = dout_ff;
  assign serial_status_oe = (state_ff == OSS_SHIFT) & ~cs_n_s;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_frame_end_ok;
    (state_ff == OSS_SHIFT) && cs_rise && count_ok && !sleep;
  endsequence

  sequence s_bit_fall;
    (state_ff == OSS_SHIFT) && sclk_fall && !cs_rise && !sleep;
  endsequence

  AST_APPLY_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
    s_frame_end_ok |=> (cmd_ff == $past(shift_ff)))
    else $error("command not applied on select rise");

  AST_HOLD_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == OSS_SHIFT && !cs_rise && !sleep) |=> $stable(cmd_ff))
    else $error("command changed mid transfer");

  AST_BAD_COUNT: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_SHIFT) && cs_rise && !count_ok) |=> $stable(cmd_ff))
    else $error("bad count transfer applied");

  AST_LOAD_STATUS: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_IDLE) && cs_fall && !sleep) |=> (shift_ff[15:8] == 8'h00)
      && (shift_ff[7:0] == $past(status_now)))
    else $error("status not loaded on select fall");

  AST_SLEEP: assert property (@(posedge mclk) disable iff (!rst_n)
    sleep |=> (cmd_ff == 16'h0000) && (state_ff == OSS_IDLE))
    else $error("sleep did not reset registers");

  AST_TRISTATE: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n_s |-> !serial_status_oe)
    else $error("output driven while deselected");

  AST_OVERVOLT: assert property (@(posedge mclk) disable iff (!rst_n)
    flt_s.over_voltage |-> (driver_on == 8'h00))
    else $error("output on during over-voltage");

  AST_THERMAL: assert property (@(posedge mclk) disable iff (!rst_n)
    (flt_s.thermal_limit[0]) |-> !driver_on[0] && status_now[0])
    else $error("thermal channel not off or unflagged");

  AST_OPEN_ON: assert property (@(posedge mclk) disable iff (!rst_n)
    (cmd_ff.out_on[1] && !flt_s.short_flt[1] && !flt_s.thermal_limit[1]) |-> !status_now[1])
    else $error("open load reported while on");

  AST_SHIFT_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_SHIFT) && sclk_rise && !cs_rise) |=> (dout_ff == $past(shift_ff[15])))
    else $error("serial output not msb first");

  AST_SHIFT_IN: assert property (@(posedge mclk) disable iff (!rst_n)
    s_bit_fall |=> (shift_ff == {$past(shift_ff[14:0]), $past(din_s)}))
    else $error("serial input bit not shifted in");

  AST_COUNT_UP: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_bit_fall ##0 (cnt_ff != {OSS_CNT_W{1'b1}}))
      |=> (cnt_ff == $past(cnt_ff) + OSS_CNT_W'(1)))
    else $error("clock count not advanced");

  AST_CNT_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_IDLE) && cs_fall) |=> (cnt_ff == '0))
    else $error("clock count not cleared at frame start");

  AST_DOUT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_SHIFT) && !sclk_rise && !cs_rise) |=> $stable(dout_ff))
    else $error("serial output changed without clock rise");

  AST_IDLE_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_IDLE) && !cs_fall) |=> $stable(shift_ff))
    else $error("shift register moved while deselected");

  AST_IDLE_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
    ((state_ff == OSS_IDLE) && !sleep) |=> $stable(cmd_ff))
    else $error("command changed outside a frame");

  AST_SHORT_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
    flt_s.short_flt[3] |-> status_now[3])
    else $error("short not flagged");

  AST_SENSE_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cmd_ff.old_en[2] && !flt_s.short_flt[2] && !flt_s.thermal_limit[2]) |-> !status_now[2])
    else $error("open load flagged with sense current off");

  AST_DRIVE_CMD: assert property (@(posedge mclk) disable iff (!rst_n)
    (!flt_s.over_voltage && !sleep && !flt_s.thermal_limit[0])
      |-> (driver_on[0] == cmd_ff.out_on[0]))
    else $error("output one not following command");

  AST_DIRECT_FIFTH: assert property (@(posedge mclk) disable iff (!rst_n)
    (dd5_s && !flt_s.over_voltage && !sleep && !flt_s.thermal_limit[4]) |-> driver_on[4])
    else $error("direct drive five not applied");

  AST_DIRECT_SIXTH: assert property (@(posedge mclk) disable iff (!rst_n)
    (dd6_s && !flt_s.over_voltage && !sleep && !flt_s.thermal_limit[5]) |-> driver_on[5])
    else $error("direct drive six not applied");

  AST_SLEEP_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
    sleep |-> (driver_on == 8'h00) && (sense_current_en == 8'h00))
    else $error("outputs active in sleep");

  AST_SENSE_EN: assert property (@(posedge mclk) disable iff (!rst_n)
    !sleep |-> (sense_current_en == cmd_ff.old_en))
    else $error("sense current not following command");

endmodule : oss_serial_ctrl
`default_nettype wire

// ---- logic/oss_pkg.sv ----
// Package for the octal switch serial control block: word layout, encodings, counts.
// Assumes a single 40 MHz system clock domain.
package oss_pkg;

  localparam int OSS_WORD_BITS = 16;
  localparam int OSS_CHAN_NUM = 8;
  localparam int OSS_CMD_OUT_LSB = 0;
  localparam int OSS_CMD_OLD_LSB = 8;
  localparam int OSS_MIN_BITS = 16;
  localparam int OSS_STEP_BITS = 8;
  localparam int OSS_CNT_W = 12;
  localparam logic [15:0] OSS_CMD_RESET = 16'h0000;
  localparam logic [7:0] OSS_STAT_HIGH = 8'h00;
  localparam int OSS_SYNC_STAGES = 2;

  typedef struct packed {
    logic [7:0] old_en;
    logic [7:0] out_on;
  } oss_cmd_t;

  typedef struct packed {
    logic [7:0] short_flt;
    logic [7:0] open_flt;
    logic [7:0] thermal_limit;
    logic over_voltage;
  } oss_fault_t;

  typedef enum logic [1:0] {
    OSS_IDLE,
    OSS_SHIFT
  } oss_state_t;

endpackage : oss_pkg

// ---- logic/oss_sync.sv ----
// Two-flip-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes inputs arrive from pins outside the mclk domain.
`timescale 1ns/1ps
`default_nettype none
module oss_sync
  import oss_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : oss_sync
`default_nettype wire

// ---- tb/oss_master_model.sv ----
// Behavioural serial bus master for the octal switch serial control block.
// Assumes the bench calls xfer between frames; serial clock period 200 ns.
`timescale 1ns/1ps
`default_nettype none
module oss_master_model (
  // Link pins
  output logic chip_select_n,
  output logic serial_clk,
  output logic serial_command_in,
  input wire logic serial_status_in
);
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_command_in = 1'b0;
  end

  // Shifts n bits of tx out MSB first, gathers the reply
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    chip_select_n = 1'b0; // Clock low at select edges
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      serial_command_in = tx[i];
      serial_clk = 1'b1;
      #100;
      serial_clk = 1'b0;
      #100;
      rx = {rx[30:0], serial_status_in};
    end
    #150;
    chip_select_n = 1'b1;
    serial_command_in = ~serial_command_in;
    #300;
  endtask : xfer
endmodule : oss_master_model
`default_nettype wire

// ---- tb/oss_serial_ctrl_tb_top.sv ----
// Self-checking bench for the octal switch serial control block.
// Assumes oss_master_model drives the link; faults come from the bench.
`timescale 1ns/1ps
`default_nettype none
module oss_serial_ctrl_tb_top;
  import oss_pkg::*;
  logic mclk, rst_n, enable, sup_ok, dd5, dd6, ov, cs_n, sclk, mosi, so, soe;
  logic [7:0] shrt, opn, thl, drv, sen;
  logic [15:0] cmd_w, cur, lf;
  logic [31:0] rx;
  wire logic miso;
  int err_count, checks_done;
  assign miso = soe ? so : 1'bz;

  oss_serial_ctrl dut (.mclk(mclk), .rst_n(rst_n), .chip_select_n(cs_n), .serial_clk(sclk),
    .serial_command_in(mosi), .serial_status_out(so), .serial_status_oe(soe),
    .enable(enable), .logic_supply_ok(sup_ok), .direct_drive_fifth(dd5),
    .direct_drive_sixth(dd6), .short_fault(shrt), .open_load_fault(opn),
    .thermal_limit(thl), .over_voltage(ov), .driver_on(drv), .sense_current_en(sen),
    .output_command_word(cmd_w));
  oss_master_model m (.chip_select_n(cs_n), .serial_clk(sclk), .serial_command_in(mosi),
    .serial_status_in(miso));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx

  function automatic logic [7:0] exp_drv();
    return (cur[7:0] | {2'h0, dd6, dd5, 4'h0}) & ~thl & {8{~ov}};
  endfunction : exp_drv

  function automatic logic [7:0] exp_stat();
    return shrt | thl | (opn & ~cur[7:0] & cur[15:8]);
  endfunction : exp_stat

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic frame(input int n, input logic [31:0] tx);
    logic [31:0] st;
    logic [31:0] mk;
    st = {24'h000000, exp_stat()};
    mk = (32'h1 << (n - 16)) - 32'h1;
    repeat (4) @(negedge mclk);
    m.xfer(n, tx, rx);
    if (n >= 16 && n % 8 == 0) cur = tx[15:0];
    if (n < 16) chk("short status", st >> (16 - n), rx);
    else chk("status", st, (rx >> (n - 16)) & 32'h0000FFFF);
    if (n > 16) chk("chain", (tx >> 16) & mk, rx & mk);
    chk("command", 32'(cur), 32'(cmd_w));
    chk("sense", 32'(cur[15:8]), 32'(sen));
    chk("drive", 32'(exp_drv()), 32'(drv));
    chk("oe", 32'h0, 32'(soe));
  endtask : frame

  // ----------------------------------------
  // Clock, stimulus, watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  initial begin
    {rst_n, dd5, dd6, ov, shrt, opn, thl, cur} = '0;
    {enable, sup_ok} = 2'h3;
    lf = 16'h7F39;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    chk("reset", 32'h0, {16'h0000, cmd_w});
    for (int k = 0; k < 12; k++) begin
      lf = nx(lf);
      opn = lf[7:0];
      shrt = lf[15:8] & lf[11:4];
      dd5 = lf[0];
      lf = nx(lf);
      thl = lf[7:0] & lf[15:8];
      dd6 = lf[9];
      frame(16, {16'h0000, nx(lf)});
    end
    frame(32, 32'h5A3C00FF);
    frame(17, 32'h0001FFFF);
    frame(15, 32'h00000000);
    frame(24, 32'h00ABCDEF);
    ov = 1'b1;
    repeat (6) @(negedge mclk);
    chk("ov drive", 32'h0, {24'h000000, drv});
    ov = 1'b0;
    repeat (6) @(negedge mclk);
    chk("ov resume", 32'(exp_drv()), 32'(drv));
    frame(16, 32'h0000FF00);
    enable = 1'b0;
    repeat (6) @(negedge mclk);
    chk("sleep en", 32'h0, {sen, drv, cmd_w});
    enable = 1'b1;
    cur = 16'h0000;
    frame(16, 32'h0000FFFF);
    sup_ok = 1'b0;
    repeat (6) @(negedge mclk);
    chk("sleep sup", 32'h0, {sen, drv, cmd_w});
    sup_ok = 1'b1;
    complete_run();
  end
endmodule : oss_serial_ctrl_tb_top
`default_nettype wire
